// ---- rtl/mwg_pkg.sv ----
// shared constants and carrier types for the memory map write guard
// assumes one 10 MHz clock and a synchronous, active-low core reset
package mwg_pkg;

  // address space shape
  localparam int DAW = 15;                       // data byte address bits
  localparam int PAW = 16;                       // program word address bits
  localparam int FAW = 17;                       // flash byte address bits
  localparam int BYTE_FLAG_BIT = 15;             // data address bit: 1 = byte

  // data-side regions, byte addresses
  localparam logic [14:0] WIN_BASE = 15'h0000;
  localparam logic [14:0] WIN_LAST = 15'h3fff;
  localparam logic [14:0] REG_BASE = 15'h4000;
  localparam logic [14:0] REG_LAST = 15'h4fff;
  localparam logic [14:0] SYSREG_BASE = 15'h4800;
  localparam logic [14:0] INFO_BASE = 15'h5000;
  localparam logic [14:0] INFO_LAST = 15'h53ff;
  localparam logic [14:0] RAM_BASE = 15'h6c00;
  localparam logic [14:0] RAM_LAST = 15'h7fff;

  // program-side regions, word addresses
  localparam logic [15:0] PFLASH_LAST = 16'hdfff;
  localparam logic [15:0] PRAM_BASE = 16'hf600;

  // ram protection segments and flash pages
  localparam int SEG_SHIFT = 5;                  // 32-byte segments
  localparam int SEG_NUM = 160;
  localparam int PERM_WORDS = 10;
  localparam logic [15:0] PERM_RST = 16'hffff;   // 1 = restricted write allowed
  localparam int PAGE_SHIFT = 10;                // 1024-byte pages
  localparam int PAGE_BITS = 7;

  // guard register indices on the plain register port
  localparam logic [3:0] RG_CTRL = 4'h0;
  localparam logic [3:0] RG_STATUS = 4'h1;
  localparam logic [3:0] RG_FADDR = 4'h2;
  localparam logic [3:0] RG_FDATA = 4'h3;
  localparam logic [3:0] RG_ERASE = 4'h4;
  localparam logic [3:0] RG_PERM0 = 4'h8;

  // field positions
  localparam int ST_VIOL = 0;
  localparam int ST_OVR = 1;
  localparam int ST_PROG_EN = 2;
  localparam int ST_ACC_ERR = 3;
  localparam int ST_SRC = 4;
  localparam int ER_INFO = 7;
  localparam int ER_GO = 8;
  localparam logic [2:0] WIN_SEL_RST = 3'h0;

  typedef logic [PERM_WORDS-1:0][15:0] mwg_perm_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [15:0] addr;                           // bit 15 sizes the access
    logic [15:0] wdata;
  } mwg_dreq_t;

  typedef struct packed {
    logic flash_rd;
    logic flash_wr;
    logic info_rd;
    logic info_wr;
    logic reg_rd;
    logic reg_wr;
    logic ram_rd;
    logic ram_wr;
    logic unmapped;
    logic blocked;
    logic byte_acc;
    logic [FAW-1:0] addr;
    logic [15:0] wdata;
  } mwg_dout_t;

  typedef struct packed {
    logic flash;
    logic ram;
    logic unmapped;
    logic [15:0] addr;
  } mwg_pout_t;

  typedef struct packed {
    logic go;
    logic info;
    logic [FAW-1:0] addr;
  } mwg_erase_t;

  typedef struct packed {
    mwg_dout_t dout;
    mwg_pout_t pout;
    mwg_erase_t erase;
    logic [2:0] win_sel;
    logic viol;
    logic ovr;
    logic acc_err;
    logic fault_src;
    logic [15:0] f_addr;
    logic [15:0] f_data;
    logic [15:0] rdata;
  } mwg_top_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } mwg_sync_st_t;

endpackage : mwg_pkg

// ---- rtl/mwg_sync2.sv ----
// two-flop synchroniser for a level arriving from a pin
// assumes the level changes slowly compared with the clock
`timescale 1ns/1ps
module mwg_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  import mwg_pkg::*;

  mwg_sync_st_t st_q;
  mwg_sync_st_t st_d;

  // first flop feeds only the second
  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;

endmodule : mwg_sync2

// ---- rtl/mwg_perm_tab.sv ----
// per-segment write permission table for the ram
// assumes writes are already gated by the caller for mode checks
`timescale 1ns/1ps
module mwg_perm_tab (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [3:0] widx,
  input wire logic [15:0] wdata,
  input wire logic [3:0] ridx,
  output logic [15:0] rword,
  input wire logic [7:0] seg,
  output logic allow
);
  import mwg_pkg::*;

  mwg_perm_t st_q;
  mwg_perm_t st_d;

  // word-wide update, out-of-range index ignored
  always_comb begin
    st_d = st_q;
    if (wr && (32'(widx) < PERM_WORDS)) begin
      st_d[widx] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= {PERM_WORDS{PERM_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // lookups read the flops directly, caller registers the result
  assign rword = (32'(ridx) < PERM_WORDS) ? st_q[ridx] : 16'h0000;
  assign allow = (32'(seg) < SEG_NUM) ? st_q[seg[7:4]][seg[3:0]] : 1'b0;

endmodule : mwg_perm_tab

// ---- rtl/mwg_top.sv ----
// memory map decoder and write guard between core buses and memories
// assumes core requests are on clk; the debug enable comes from a pin
//
// Functional notes
// - data addresses bytes, program addresses words
// - data space 15 bits, program 16 bits
// - data address bit 15 marks byte access
// - program flash: first 56k words direct
// - program flash fetches are whole words
// - eight 16kB sections into data window
// - flash reads any size, writes whole words
// - info page decoded at 0x5000, 1024 bytes
// - info page: byte read, word write, whole erase
// - info programming only with debug enable
// - ram at top 2.5k program words
// - ram in last 5kB of data space
// - 32-byte ram segments, restricted-write permission each; here only segments 0-127 are settable, 128-159 stay allowed
// - ram reads always; privileged writes always
// - peripheral registers decoded from 0x4000
// - system registers shielded from restricted mode
// - restricted protected writes captured for diagnosis
// - flash erase works on 1024-byte pages
// - upper 16kB reached only through window
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module mwg_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sys_mode,
  input mwg_pkg::mwg_dreq_t dreq,
  input wire logic preq_valid,
  input wire logic [15:0] preq_addr,
  input wire logic dbg_prog_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output mwg_pkg::mwg_dout_t dout,
  output mwg_pkg::mwg_pout_t pout,
  output mwg_pkg::mwg_erase_t erase,
  output logic viol_flag
);
  import mwg_pkg::*;

  mwg_top_st_t st_q;
  mwg_top_st_t st_d;

  logic prog_en;
  logic [15:0] perm_rword;
  logic seg_allow;
  logic perm_wr;
  logic [14:0] da;
  logic byte_acc;
  logic [14:0] ram_off;

  // inclusive range test, shared by every data region decode
  function automatic logic in_rng(input logic [14:0] a,
                                  input logic [14:0] lo,
                                  input logic [14:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // guard registers that restricted software may not write
  function automatic logic guarded_reg(input logic [3:0] idx);
    guarded_reg = (idx == RG_CTRL) || (idx == RG_ERASE) ||
                  (idx >= RG_PERM0);
  endfunction : guarded_reg

  // debug enable arrives from a pin, so resynchronise it
  mwg_sync2 u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(dbg_prog_en),
    .dout(prog_en)
  );

  // data address split: low 15 bits locate, bit 15 sizes
  assign da = dreq.addr[DAW-1:0];
  assign byte_acc = dreq.addr[BYTE_FLAG_BIT];
  assign ram_off = da - RAM_BASE;

  // permission table writes only from privileged software
  assign perm_wr = reg_wr && sys_mode && (reg_addr >= RG_PERM0);

  mwg_perm_tab u_perm (
    .clk(clk),
    .rst_n(rst_n),
    .wr(perm_wr),
    .widx(reg_addr - RG_PERM0),
    .wdata(reg_wdata),
    .ridx(reg_addr - RG_PERM0),
    .rword(perm_rword),
    .seg(ram_off[12:SEG_SHIFT]),
    .allow(seg_allow)
  );

  // main next-state logic
  always_comb begin
    logic dviol;
    logic rviol;
    logic [15:0] clr;
    dviol = 1'b0;
    rviol = 1'b0;
    clr = 16'h0000;
    st_d = st_q;

    // per-cycle pulses fall back to idle
    st_d.dout = '0;
    st_d.pout = '0;
    st_d.erase = '0;
    st_d.rdata = 16'h0000;

    // program side: word addresses only, always full words
    if (preq_valid) begin
      st_d.pout.addr = preq_addr;
      if (preq_addr <= PFLASH_LAST) begin
        st_d.pout.flash = 1'b1;
      end else if (preq_addr >= PRAM_BASE) begin
        st_d.pout.ram = 1'b1;
        st_d.pout.addr = preq_addr - PRAM_BASE;
      end else begin
        st_d.pout.unmapped = 1'b1;
      end
    end

    // data side decode
    if (dreq.valid) begin
      st_d.dout.byte_acc = byte_acc;
      st_d.dout.wdata = dreq.wdata;
      if (in_rng(da, WIN_BASE, WIN_LAST)) begin
        // section select forms the top flash bits; the upper
        // 16kB has no program alias, only this window reaches it
        st_d.dout.addr = {st_q.win_sel, da[13:0]};
        if (!dreq.wr) begin
          st_d.dout.flash_rd = 1'b1;
        end else if (!byte_acc) begin
          st_d.dout.flash_wr = 1'b1;
        end else begin
          st_d.dout.blocked = 1'b1;
          st_d.acc_err = 1'b1;
        end
      end else if (in_rng(da, REG_BASE, REG_LAST)) begin
        st_d.dout.addr = {2'h0, da};
        if (!dreq.wr) begin
          st_d.dout.reg_rd = 1'b1;
        end else if (!sys_mode && (da >= SYSREG_BASE)) begin
          st_d.dout.blocked = 1'b1;
          dviol = 1'b1;
        end else begin
          st_d.dout.reg_wr = 1'b1;
        end
      end else if (in_rng(da, INFO_BASE, INFO_LAST)) begin
        st_d.dout.addr = {7'h00, da[9:0]};
        if (!dreq.wr) begin
          st_d.dout.info_rd = 1'b1;
        end else if (!byte_acc && prog_en) begin
          st_d.dout.info_wr = 1'b1;
        end else begin
          st_d.dout.blocked = 1'b1;
          st_d.acc_err = 1'b1;
        end
      end else if (in_rng(da, RAM_BASE, RAM_LAST)) begin
        st_d.dout.addr = {4'h0, ram_off[12:0]};
        if (!dreq.wr) begin
          st_d.dout.ram_rd = 1'b1;
        end else if (sys_mode || seg_allow) begin
          st_d.dout.ram_wr = 1'b1;
        end else begin
          st_d.dout.blocked = 1'b1;
          dviol = 1'b1;
        end
      end else begin
        st_d.dout.unmapped = 1'b1;
      end
    end

    // register port writes
    if (reg_wr) begin
      if (!sys_mode && guarded_reg(reg_addr)) begin
        rviol = 1'b1;
      end else if (reg_addr == RG_CTRL) begin
        st_d.win_sel = reg_wdata[2:0];
      end else if (reg_addr == RG_STATUS) begin
        clr = reg_wdata; // write one to clear
      end else if (reg_addr == RG_ERASE) begin
        if (reg_wdata[ER_GO]) begin
          if (reg_wdata[ER_INFO] && !prog_en) begin
            st_d.acc_err = 1'b1;
          end else begin
            st_d.erase.go = 1'b1;
            st_d.erase.info = reg_wdata[ER_INFO];
            // page number lands on a 1024-byte boundary
            st_d.erase.addr = reg_wdata[ER_INFO] ? '0 :
              {reg_wdata[PAGE_BITS-1:0], 10'h000};
          end
        end
      end
    end

    // clears first, so an event in the same cycle still wins
    if (clr[ST_VIOL]) st_d.viol = 1'b0;
    if (clr[ST_OVR]) st_d.ovr = 1'b0;
    if (clr[ST_ACC_ERR] && !(st_d.acc_err && !st_q.acc_err)) begin
      st_d.acc_err = 1'b0;
    end
    if (dreq.valid && st_d.dout.blocked && !dviol) begin
      st_d.acc_err = 1'b1;
    end

    // capture the first errant write; later ones only mark overrun
    if (dviol || rviol) begin
      if (st_q.viol && !clr[ST_VIOL]) begin
        st_d.ovr = 1'b1;
      end else begin
        st_d.fault_src = !dviol;
        st_d.f_addr = dviol ? dreq.addr : {12'h000, reg_addr};
        st_d.f_data = dviol ? dreq.wdata : reg_wdata;
      end
      st_d.viol = 1'b1;
    end

    // read data stands one cycle after the strobe only
    if (reg_rd) begin
      unique case (reg_addr)
        RG_CTRL: st_d.rdata = {13'h0000, st_q.win_sel};
        RG_STATUS: begin
          st_d.rdata = 16'h0000;
          st_d.rdata[ST_VIOL] = st_q.viol;
          st_d.rdata[ST_OVR] = st_q.ovr;
          st_d.rdata[ST_PROG_EN] = prog_en;
          st_d.rdata[ST_ACC_ERR] = st_q.acc_err;
          st_d.rdata[ST_SRC] = st_q.fault_src;
        end
        RG_FADDR: st_d.rdata = st_q.f_addr;
        RG_FDATA: st_d.rdata = st_q.f_data;
        default: st_d.rdata = (reg_addr >= RG_PERM0) ? perm_rword :
                              16'h0000;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.win_sel <= WIN_SEL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // every output is a flop of the state
  assign dout = st_q.dout;
  assign pout = st_q.pout;
  assign erase = st_q.erase;
  assign reg_rdata = st_q.rdata;
  assign viol_flag = st_q.viol;

endmodule : mwg_top

// ---- sim/mwg_core_model.sv ----
// behavioural core: drives the data and program bus requests
// assumes the bench calls one task at a time, clocked by clk
`timescale 1ns/1ps
module mwg_core_model (
  input wire logic clk,
  output mwg_pkg::mwg_dreq_t dreq,
  output logic preq_valid,
  output logic [15:0] preq_addr,
  output logic sys_mode
);
  import mwg_pkg::*;
  // core starts privileged, buses idle
  initial begin
    dreq = '0;
    preq_valid = 1'b0;
    preq_addr = 16'h0;
    sys_mode = 1'b1;
  end
  // mode only changes between accesses
  task automatic mode(input logic m);
    @(posedge clk);
    sys_mode <= m;
  endtask : mode
  // one data access, released lines wander so stale values never match
  task automatic dacc(input logic w, input logic [15:0] a,
                      input logic [15:0] d);
    logic [15:0] x;
    x = a;
    if (x[14:12] == 3'h4) begin
      x[15] = 1'b0;
    end
    @(posedge clk);
    dreq <= {1'b1, w, x, d};
    @(posedge clk);
    dreq <= {1'b0, 1'b0, ~x, ~d};
    @(negedge clk);
  endtask : dacc
  // one program fetch, always a whole word
  task automatic fetch(input logic [15:0] a);
    @(posedge clk);
    preq_valid <= 1'b1;
    preq_addr <= a;
    @(posedge clk);
    preq_valid <= 1'b0;
    preq_addr <= ~a;
    @(negedge clk);
  endtask : fetch
endmodule : mwg_core_model

// ---- sim/mwg_top_assertions.sv ----
// concurrent checks on the guard's ports
// assumes binding into mwg_top; single clock domain
`timescale 1ns/1ps
module mwg_top_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sys_mode,
  input mwg_pkg::mwg_dreq_t dreq,
  input wire logic preq_valid,
  input wire logic [15:0] preq_addr,
  input wire logic dbg_prog_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input mwg_pkg::mwg_dout_t dout,
  input mwg_pkg::mwg_pout_t pout,
  input mwg_pkg::mwg_erase_t erase,
  input wire logic viol_flag
);
  import mwg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request shapes, each used by one check
  sequence s_ram_wr;
    dreq.valid && dreq.wr && dreq.addr[14:0] >= RAM_BASE;
  endsequence
  // pin low long enough to have passed the two sync flops
  sequence s_no_dbg;
    !dbg_prog_en [*3];
  endsequence
  byte_size_a: assert property (
    dreq.valid |=> dout.byte_acc == $past(dreq.addr[15]))
    else $error("byte flag wrong");
  ram_map_a: assert property (
    dreq.valid && !dreq.wr && dreq.addr[14:0] >= RAM_BASE |=>
    dout.ram_rd && dout.addr == {2'h0, $past(dreq.addr[14:0]) - RAM_BASE})
    else $error("ram read map wrong");
  priv_ram_a: assert property (
    s_ram_wr ##0 sys_mode |=> dout.ram_wr && !dout.blocked)
    else $error("privileged ram write lost");
  win_byte_a: assert property (
    dreq.valid && dreq.wr && dreq.addr[15] && !dreq.addr[14] |=>
    dout.blocked && !dout.flash_wr)
    else $error("byte flash write passed");
  sysreg_a: assert property (
    dreq.valid && dreq.wr && !sys_mode && dreq.addr[14:11] == 4'h9 |=>
    dout.blocked && !dout.reg_wr && viol_flag)
    else $error("system register not shielded");
  reg_map_a: assert property (
    dreq.valid && dreq.wr && dreq.addr[14:11] == 4'h8 |=>
    dout.reg_wr && dout.addr == {2'h0, $past(dreq.addr[14:0])})
    else $error("register decode wrong");
  info_lock_a: assert property (
    s_no_dbg ##0 (dreq.valid && dreq.wr && dreq.addr[14:10] == 5'h14)
    |=> dout.blocked && !dout.info_wr)
    else $error("info write without enable");
  pflash_a: assert property (
    preq_valid && preq_addr <= PFLASH_LAST |=>
    pout.flash && pout.addr == $past(preq_addr))
    else $error("program flash map wrong");
  pram_a: assert property (
    preq_valid && preq_addr >= PRAM_BASE |=>
    pout.ram && pout.addr == $past(preq_addr) - PRAM_BASE)
    else $error("program ram map wrong");
  viol_hold_a: assert property (
    viol_flag && !(reg_wr && reg_addr == RG_STATUS) |=> viol_flag)
    else $error("violation flag dropped");
  erase_page_a: assert property (
    reg_wr && sys_mode && reg_addr == RG_ERASE && reg_wdata[ER_GO] &&
    !reg_wdata[ER_INFO] |=> erase.go &&
    erase.addr == {$past(reg_wdata[6:0]), 10'h0} ##1 !erase.go)
    else $error("page erase wrong");
endmodule : mwg_top_assertions
bind mwg_top mwg_top_assertions u_chk (
  .clk(clk), .rst_n(rst_n), .sys_mode(sys_mode), .dreq(dreq),
  .preq_valid(preq_valid), .preq_addr(preq_addr),
  .dbg_prog_en(dbg_prog_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .dout(dout), .pout(pout),
  .erase(erase), .viol_flag(viol_flag));

// ---- sim/tb.sv ----
// self-checking bench for the memory map write guard
// assumes the core model drives the buses; bench owns the register port
`timescale 1ns/1ps
module tb;
  import mwg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dbg_prog_en = 1'b0;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic sys_mode;
  logic preq_valid;
  logic [15:0] preq_addr;
  logic viol_flag;
  mwg_dreq_t dreq;
  mwg_dout_t dout;
  mwg_pout_t pout;
  mwg_erase_t erase;
  int n_fail = 0;
  int cmp_count = 0;
  logic [15:0] pa [4] = '{16'h0000, 16'hdfff, 16'hf600, 16'hffff};
  logic [18:0] pe [4] = '{19'h40000, 19'h4dfff, 19'h20000, 19'h209ff};
  always #50 clk = ~clk;
  mwg_core_model core (.clk(clk), .dreq(dreq), .preq_valid(preq_valid),
    .preq_addr(preq_addr), .sys_mode(sys_mode));
  mwg_top dut (.clk(clk), .rst_n(rst_n), .sys_mode(sys_mode),
    .dreq(dreq), .preq_valid(preq_valid), .preq_addr(preq_addr),
    .dbg_prog_en(dbg_prog_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dout(dout), .pout(pout), .erase(erase),
    .viol_flag(viol_flag));
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // register write, effect visible after the taking edge
  task automatic rw(input logic [3:0] i, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= i;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask : rw
  // read data stands only in the cycle after the strobe
  task automatic rr(input logic [3:0] i, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= i;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", reg_rdata, e);
  endtask : rr
  // decode flags and address of the last data access
  task automatic cd(input logic [10:0] f, input logic [16:0] a);
    chk("dout", dout[43:16], {f, a});
  endtask : cd
  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // hang guard, tests need about a hundred cycles
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    // register port idle before the first edge
    reg_addr <= 4'h0;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rr(RG_CTRL, 16'h0000);
    rr(RG_PERM0, PERM_RST);
    rr(RG_STATUS, 16'h0000);
    done("reset");
    for (int k = 0; k < 4; k++) begin
      core.fetch(pa[k]);
      chk("pout", pout, pe[k]);
    end
    core.fetch(16'hf5ff);
    chk("unmapped", pout.unmapped, 1'b1);
    done("program");
    rw(RG_CTRL, 16'h0005);
    core.dacc(1'b0, 16'h8123, 16'h0);
    cd(11'h401, {3'h5, 14'h0123});
    core.mode(1'b0);
    rw(RG_CTRL, 16'h0002);
    rr(RG_CTRL, 16'h0005);
    rr(RG_STATUS, 16'h0011);
    rr(RG_FDATA, 16'h0002);
    rw(RG_STATUS, 16'h000b);
    chk("viol", viol_flag, 1'b0);
    done("window");
    core.mode(1'b1);
    rw(RG_PERM0, 16'hfffd);
    rr(RG_PERM0, 16'hfffd);
    core.mode(1'b0);
    core.dacc(1'b1, 16'h6c20, 16'h1234);
    chk("blocked", dout.blocked, 1'b1);
    chk("viol", viol_flag, 1'b1);
    core.dacc(1'b1, 16'h6c40, 16'h5678);
    cd(11'h008, 17'h00040);
    chk("wdata", dout.wdata, 16'h5678);
    core.dacc(1'b1, 16'h6c3e, 16'h0);
    rr(RG_FADDR, 16'h6c20);
    rr(RG_FDATA, 16'h1234);
    rr(RG_STATUS, 16'h0003);
    core.dacc(1'b0, 16'h6c20, 16'h0);
    cd(11'h010, 17'h00020);
    core.mode(1'b1);
    core.dacc(1'b1, 16'h6c20, 16'h9abc);
    cd(11'h008, 17'h00020);
    rw(RG_STATUS, 16'h000b);
    done("ram");
    core.mode(1'b0);
    core.dacc(1'b1, 16'h4002, 16'h0);
    cd(11'h020, 17'h04002);
    core.dacc(1'b1, 16'h4800, 16'h0);
    chk("blocked", dout.blocked, 1'b1);
    rr(RG_FADDR, 16'h4800);
    rw(RG_STATUS, 16'h000b);
    core.dacc(1'b0, 16'h6000, 16'h0);
    chk("unmapped", dout.unmapped, 1'b1);
    core.dacc(1'b1, 16'h8010, 16'h0);
    chk("blocked", dout.blocked, 1'b1);
    core.dacc(1'b1, 16'h0010, 16'h0);
    cd(11'h200, 17'h14010);
    done("registers");
    core.dacc(1'b0, 16'hd003, 16'h0);
    cd(11'h101, 17'h00003);
    core.dacc(1'b1, 16'h5010, 16'h0);
    chk("blocked", dout.blocked, 1'b1);
    rr(RG_STATUS, 16'h0008);
    @(posedge clk);
    dbg_prog_en <= 1'b1;
    repeat (3) @(posedge clk);
    core.dacc(1'b1, 16'h5010, 16'h0);
    cd(11'h080, 17'h00010);
    core.dacc(1'b1, 16'hd010, 16'h0);
    chk("blocked", dout.blocked, 1'b1);
    rr(RG_STATUS, 16'h000c);
    core.mode(1'b1);
    rw(RG_ERASE, 16'h0180);
    chk("erase", erase, {2'b11, 17'h0});
    rw(RG_ERASE, 16'h0105);
    chk("erase", erase, {2'b10, 17'h01400});
    done("info");
    print_verdict();
  end
endmodule : tb
